// ===== rtl/jls_defs.svh
// Constants for the link startup block
// Function
// RULE1 - Default K: 8 four-lane, 4 two-lane
// RULE2 - K from low five bits at 0x006
// RULE3 - Source keeps SYSREF at or below 250MHz/K
// RULE4 - Host selects page 00h/69h before K
// RULE5 - Comma characters while SYNC low
// RULE6 - SYNC high: alignment sequence then samples
// RULE7 - Host reset pulse at least 10 ns
// RULE8 - Host waits 100 ns before write enable
// RULE9 - Host waits 1 ms before reset; the bench drives reset low from time 0 with no wait
// RULE10 - Host writes 80h to 0x000 for K
// RULE11 - Lane mode 02h two-lane, 01h four-lane
`ifndef JLS_DEFS_SVH
`define JLS_DEFS_SVH
`define JLS_ADDR_KCTRL 8'h00
`define JLS_ADDR_LANE 8'h01
`define JLS_ADDR_PSEL_LO 8'h03
`define JLS_ADDR_PSEL_HI 8'h04
`define JLS_ADDR_KLEN 8'h06
`define JLS_ADDR_STATUS 8'h08
`define JLS_PAGE_LO_JESD 8'h00
`define JLS_PAGE_HI_JESD 8'h69
`define JLS_KCTRL_EN 8'h80
`define JLS_LANE_FOUR 8'h01
`define JLS_LANE_TWO 8'h02
`define JLS_K_FOUR 5'h08
`define JLS_K_TWO 5'h04
`define JLS_ILA_MULTIFRAMES 3'h4
`define JLS_COMMA 8'hbc
`define JLS_ILA_START 8'h1c
`define JLS_ILA_END 8'h7c
`endif

// ===== rtl/jls_pkg.sv
// Types for the link startup block
package jls_pkg;
  typedef enum logic [2:0] {
    JLS_COMMA_ST = 3'b001,
    JLS_ILA_ST = 3'b010,
    JLS_DATA_ST = 3'b100
  } jls_state_t;
endpackage

// ===== rtl/jls_fifo.sv
// Sample FIFO with valid/ready on both sides
`timescale 1ns/1ns
module jls_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_resetn,
  // Fill side
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  // Drain side
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
  logic push, pop;
  always_comb begin
    o_in_ready = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
    o_out_valid = wr_ptr != rd_ptr;
    push = i_in_valid && o_in_ready;
    pop = o_out_valid && i_out_ready;
    next_wr_ptr = wr_ptr + (AW+1)'(push);
    next_rd_ptr = rd_ptr + (AW+1)'(pop);
    o_out_data = mem[rd_ptr[AW-1:0]];
  end
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
    end
  end
  always_ff @(posedge i_clock) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= i_in_data;
    end
  end
endmodule // jls_fifo

// ===== rtl/jls_link.sv
// Link startup: registers, lane alignment and sample stream
`timescale 1ns/1ns
`include "jls_defs.svh"
module jls_link
  import jls_pkg::*;
(
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_resetn,
  // Wishbone slave
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [31:0] i_wb_dat,
  input wire logic [3:0] i_wb_sel,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  // Receiver sync pin
  input wire logic i_sync,
  // Converter samples
  input wire logic i_sample_valid,
  input wire logic [15:0] i_sample,
  output logic o_sample_ready,
  // Lane output
  input wire logic i_lane_ready,
  output logic [7:0] o_lane_data,
  output logic o_lane_is_k,
  output logic o_lane_valid,
  // Link status
  output logic o_two_lane_mode,
  output logic [4:0] o_k_frames
);
  logic [7:0] kctrl, lane, psel_lo, psel_hi, klen;
  logic [7:0] next_kctrl, next_lane, next_psel_lo, next_psel_hi, next_klen;
  logic ack, next_ack, k_written, next_k_written;
  logic [31:0] rdat, next_rdat;
  logic sync_meta, sync_q;
  jls_state_t state, next_state;
  logic [4:0] frame_cnt, next_frame_cnt;
  logic [2:0] mf_cnt, next_mf_cnt;
  logic byte_hi, next_byte_hi;
  logic [7:0] lane_data, next_lane_data;
  logic lane_is_k, next_lane_is_k, lane_valid, next_lane_valid;
  logic fifo_valid, fifo_pop;
  logic [15:0] fifo_data;
  logic wr, rd, page_ok, two_lane, step;
  logic [4:0] k_eff;

  function automatic logic [7:0] merge(input logic [7:0] old, input logic [31:0] d, input logic [3:0] s);
    merge = s[0] ? d[7:0] : old;
  endfunction

  jls_fifo #(.WIDTH(16), .DEPTH(8)) u_fifo (
    .i_clock(i_clock),
    .i_resetn(i_resetn),
    .i_in_valid(i_sample_valid),
    .o_in_ready(o_sample_ready),
    .i_in_data(i_sample),
    .o_out_valid(fifo_valid),
    .i_out_ready(fifo_pop),
    .o_out_data(fifo_data)
  );

  always_comb begin
    wr = i_wb_cyc && i_wb_stb && i_wb_we && !ack;
    rd = i_wb_cyc && i_wb_stb && !i_wb_we && !ack;
    page_ok = (psel_lo == `JLS_PAGE_LO_JESD) && (psel_hi == `JLS_PAGE_HI_JESD);
    two_lane = lane == `JLS_LANE_TWO; // RULE11
    // Default K unless a nonzero programmed value is enabled
    k_eff = two_lane ? `JLS_K_TWO : `JLS_K_FOUR; // RULE1
    if (k_written && kctrl[7] && klen[4:0] != 5'h00) begin
      k_eff = klen[4:0]; // RULE2
    end
    next_ack = i_wb_cyc && i_wb_stb && !ack;
    next_kctrl = kctrl;
    next_lane = lane;
    next_psel_lo = psel_lo;
    next_psel_hi = psel_hi;
    next_klen = klen;
    next_k_written = k_written;
    next_rdat = rdat;
    if (wr) begin
      unique case (i_wb_adr)
        `JLS_ADDR_PSEL_LO: next_psel_lo = merge(psel_lo, i_wb_dat, i_wb_sel);
        `JLS_ADDR_PSEL_HI: next_psel_hi = merge(psel_hi, i_wb_dat, i_wb_sel);
        default: begin
          // Page-dependent registers take writes only on the digital page
          if (page_ok && i_wb_adr == `JLS_ADDR_KCTRL) next_kctrl = merge(kctrl, i_wb_dat, i_wb_sel);
          if (page_ok && i_wb_adr == `JLS_ADDR_LANE) next_lane = merge(lane, i_wb_dat, i_wb_sel);
          if (page_ok && i_wb_adr == `JLS_ADDR_KLEN && i_wb_sel[0]) begin
            next_klen = i_wb_dat[7:0]; // RULE2
            next_k_written = 1'b1;
          end
        end
      endcase
    end
    if (rd) begin
      unique case (i_wb_adr)
        `JLS_ADDR_KCTRL: next_rdat = {24'h0, kctrl};
        `JLS_ADDR_LANE: next_rdat = {24'h0, lane};
        `JLS_ADDR_PSEL_LO: next_rdat = {24'h0, psel_lo};
        `JLS_ADDR_PSEL_HI: next_rdat = {24'h0, psel_hi};
        `JLS_ADDR_KLEN: next_rdat = {24'h0, klen};
        `JLS_ADDR_STATUS: next_rdat = {24'h0, state, 5'h00};
        default: next_rdat = 32'h0;
      endcase
    end
  end

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      kctrl <= 8'h00;
      lane <= `JLS_LANE_FOUR;
      psel_lo <= 8'h00;
      psel_hi <= 8'h00;
      klen <= 8'h00;
      k_written <= 1'b0;
      ack <= 1'b0;
      rdat <= 32'h0;
    end else begin
      kctrl <= next_kctrl;
      lane <= next_lane;
      psel_lo <= next_psel_lo;
      psel_hi <= next_psel_hi;
      klen <= next_klen;
      k_written <= next_k_written;
      ack <= next_ack;
      rdat <= next_rdat;
    end
  end

  // Sync pin synchroniser
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      sync_meta <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      sync_meta <= i_sync;
      sync_q <= sync_meta;
    end
  end

  // Lane sequencer: one octet per accepted step
  always_comb begin
    step = !lane_valid || i_lane_ready;
    next_state = state;
    next_frame_cnt = frame_cnt;
    next_mf_cnt = mf_cnt;
    next_byte_hi = byte_hi;
    next_lane_data = lane_data;
    next_lane_is_k = lane_is_k;
    next_lane_valid = lane_valid;
    fifo_pop = 1'b0;
    if (!sync_q) begin
      next_state = JLS_COMMA_ST; // RULE5
      next_frame_cnt = 5'h00;
      next_mf_cnt = 3'h0;
      next_byte_hi = 1'b0;
      if (step) begin
        next_lane_data = `JLS_COMMA; // RULE5
        next_lane_is_k = 1'b1;
        next_lane_valid = 1'b1;
      end
    end else if (step) begin
      unique case (state)
        JLS_COMMA_ST: begin
          next_state = JLS_ILA_ST; // RULE6
          next_lane_data = `JLS_ILA_START;
          next_lane_is_k = 1'b1;
          next_lane_valid = 1'b1;
          next_frame_cnt = 5'h01;
        end
        JLS_ILA_ST: begin
          next_lane_valid = 1'b1;
          if (frame_cnt == k_eff - 5'h01) begin
            next_frame_cnt = 5'h00;
            next_lane_data = `JLS_ILA_END;
            next_lane_is_k = 1'b1;
            next_mf_cnt = mf_cnt + 3'h1;
            if (mf_cnt == `JLS_ILA_MULTIFRAMES - 3'h1) next_state = JLS_DATA_ST; // RULE6
          end else begin
            next_frame_cnt = frame_cnt + 5'h01;
            next_lane_data = (frame_cnt == 5'h00) ? `JLS_ILA_START : {3'h0, frame_cnt};
            next_lane_is_k = frame_cnt == 5'h00;
          end
        end
        JLS_DATA_ST: begin
          next_lane_is_k = 1'b0;
          next_lane_valid = fifo_valid;
          if (fifo_valid) begin
            next_lane_data = byte_hi ? fifo_data[7:0] : fifo_data[15:8];
            next_byte_hi = !byte_hi;
            fifo_pop = byte_hi; // RULE6
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      state <= JLS_COMMA_ST;
      frame_cnt <= 5'h00;
      mf_cnt <= 3'h0;
      byte_hi <= 1'b0;
      lane_data <= 8'h00;
      lane_is_k <= 1'b0;
      lane_valid <= 1'b0;
    end else begin
      state <= next_state;
      frame_cnt <= next_frame_cnt;
      mf_cnt <= next_mf_cnt;
      byte_hi <= next_byte_hi;
      lane_data <= next_lane_data;
      lane_is_k <= next_lane_is_k;
      lane_valid <= next_lane_valid;
    end
  end

  always_comb begin
    o_wb_ack = ack;
    o_wb_dat = rdat;
    o_lane_data = lane_data;
    o_lane_is_k = lane_is_k;
    o_lane_valid = lane_valid;
    o_two_lane_mode = two_lane;
    o_k_frames = k_eff;
  end

  property p_comma_low;
    @(posedge i_clock) disable iff (!i_resetn)
      !sync_q && (!lane_valid || i_lane_ready) |=> o_lane_data == `JLS_COMMA && o_lane_is_k && o_lane_valid;
  endproperty
  a_comma_low: assert property (p_comma_low) else $error("no comma while sync low"); // RULE5

  sequence s_sync_rise;
    !sync_q ##1 sync_q;
  endsequence
  property p_ila_after_sync;
    @(posedge i_clock) disable iff (!i_resetn)
      s_sync_rise ##0 (!lane_valid || i_lane_ready) |=> state == JLS_ILA_ST && o_lane_data == `JLS_ILA_START;
  endproperty
  a_ila_after_sync: assert property (p_ila_after_sync) else $error("no alignment start after sync"); // RULE6

  property p_no_data_early;
    @(posedge i_clock) disable iff (!i_resetn)
      !sync_q |=> state != JLS_DATA_ST;
  endproperty
  a_no_data_early: assert property (p_no_data_early) else $error("data sent while sync low"); // RULE6

  property p_default_k;
    @(posedge i_clock) disable iff (!i_resetn)
      !k_written |-> o_k_frames == (two_lane ? 5'h04 : 5'h08);
  endproperty
  a_default_k: assert property (p_default_k) else $error("wrong default multiframe length"); // RULE1

  property p_k_write;
    @(posedge i_clock) disable iff (!i_resetn)
      wr && page_ok && i_wb_adr == `JLS_ADDR_KLEN && i_wb_sel[0] |=> klen == $past(i_wb_dat[7:0]) && k_written;
  endproperty
  a_k_write: assert property (p_k_write) else $error("multiframe length not stored"); // RULE2

  property p_lane_mode;
    @(posedge i_clock) disable iff (!i_resetn)
      wr && page_ok && i_wb_adr == `JLS_ADDR_LANE && i_wb_sel[0] && i_wb_dat[7:0] == 8'h02 |=> o_two_lane_mode;
  endproperty
  a_lane_mode: assert property (p_lane_mode) else $error("two-lane mode not selected"); // RULE11

  property p_ack_one;
    @(posedge i_clock) disable iff (!i_resetn)
      o_wb_ack |=> !o_wb_ack;
  endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack held two cycles");

  property p_ack_follows;
    @(posedge i_clock) disable iff (!i_resetn)
      i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack;
  endproperty
  a_ack_follows: assert property (p_ack_follows) else $error("ack not given next cycle");
endmodule // jls_link

// ===== bench/jls_rx_model.sv
// Receiver model: sync handshake and lane backpressure
`timescale 1ns/1ns
module jls_rx_model (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_resetn,
  // Lane from device
  input wire logic i_lane_valid,
  input wire logic i_lane_is_k,
  input wire logic [7:0] i_lane_data,
  // Bench control
  input wire logic i_hold_sync,
  input wire logic i_stall,
  // To device
  output logic o_sync,
  output logic o_lane_ready
);
  int commas;
  always @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      commas <= 0;
      o_sync <= 1'b0;
      o_lane_ready <= 1'b0;
    end else begin
      // Ready prompt or slow, never while stalled
      o_lane_ready <= !i_stall && ($urandom % 4 != 0);
      if (i_hold_sync) begin
        commas <= 0;
        o_sync <= 1'b0;
      end else if (i_lane_valid && o_lane_ready && i_lane_is_k && i_lane_data == 8'hbc) begin
        commas <= commas + 1;
        if (commas >= 3) o_sync <= 1'b1;
      end
    end
  end
endmodule // jls_rx_model

// ===== bench/jls_link_tb.sv
// Self-checking bench for the link startup block
`timescale 1ns/1ns
module jls_link_tb;
  logic clk = 0, rstn = 0, cyc = 0, stb = 0, we = 0, hold = 1, stall = 0, sv = 0, en_src = 0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0, rd;
  logic [3:0] sel = 4'h0;
  logic [15:0] smp = 16'h0;
  logic [31:0] rdq, kd;
  logic ack, sr, lv, lk, rdy, sync, two;
  logic [7:0] ld;
  logic [4:0] kf;
  int n_fail = 0, cmp_count = 0, cyc_n = 0, mode = 0, idx = 0, kk = 8, hi = 1, kv, i;
  logic [15:0] sq[$];
  always #50 clk = ~clk;
  jls_link uut (.i_clock(clk), .i_resetn(rstn), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
    .i_wb_adr(adr), .i_wb_dat(wdat), .i_wb_sel(sel), .o_wb_dat(rdq), .o_wb_ack(ack), .i_sync(sync),
    .i_sample_valid(sv), .i_sample(smp), .o_sample_ready(sr), .i_lane_ready(rdy), .o_lane_data(ld),
    .o_lane_is_k(lk), .o_lane_valid(lv), .o_two_lane_mode(two), .o_k_frames(kf));
  jls_rx_model rx (.i_clock(clk), .i_resetn(rstn), .i_lane_valid(lv), .i_lane_is_k(lk), .i_lane_data(ld),
    .i_hold_sync(hold), .i_stall(stall), .o_sync(sync), .o_lane_ready(rdy));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'h1;
    do @(posedge clk); while (ack !== 1'b1);
    rd = rdq;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc_n++;
    if (cyc_n == 20000) begin
      n_fail++;
      results();
    end
  end
  // Sample source into the buffer
  always @(posedge clk) begin
    if (sv && sr) begin
      sq.push_back(smp);
      smp <= $urandom;
    end
    sv <= en_src;
  end
  // Lane monitor against the expected stream
  always @(posedge clk) if (rstn && lv && rdy) begin
    if (mode == 0) begin
      if (!(lk === 1'b1 && ld === 8'hbc)) begin
        check({lk, ld}, {23'h0, 9'h11c});
        mode = 1;
        idx = 1;
        kk = kv;
      end
    end else if (mode == 1) begin
      if (idx % kk == kk - 1) check({lk, ld}, {23'h0, 9'h17c});
      else if (idx % kk == 0) check({lk, ld}, {23'h0, 9'h11c});
      else check({lk, ld}, idx % kk);
      idx++;
      if (idx == 4 * kk) mode = 2;
    end else begin
      check(lk, 1'b0);
      if (hi) check(ld, sq[0][15:8]);
      else check(ld, sq.pop_front() & 16'h00ff);
      hi = !hi;
    end
  end
  initial begin
    void'($urandom(32'ha29c));
    // Reset for 250 ns, then a gap before the first write
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    repeat (2) @(posedge clk);
    check(kf, 5'h08);
    check(two, 1'b0);
    wb(0, 8'h01, 0);
    check(rd, 32'h01);
    $display("test reset defaults done");
    kv = 2 + $urandom % 30;
    kd = {24'h0, 3'($urandom), 5'(kv)};
    wb(1, 8'h00, 32'h80);
    wb(1, 8'h06, kd);
    check(kf, 5'h08);
    wb(1, 8'h03, 32'h00);
    wb(1, 8'h04, 32'h69);
    wb(1, 8'h06, kd);
    check(kf, 5'h08);
    wb(1, 8'h00, 32'h80);
    check(kf, 5'(kv));
    wb(0, 8'h06, 0);
    check(rd, kd);
    wb(1, 8'h01, 32'h02);
    check(two, 1'b1);
    wb(1, 8'h00, 32'h00);
    check(kf, 5'h04);
    wb(1, 8'h00, 32'h80);
    wb(1, 8'h01, 32'h01);
    check({two, kf}, {1'b0, 5'(kv)});
    wb(0, 8'h20, 0);
    check(rd, 32'h0);
    $display("test registers done");
    stall <= 1'b1;
    en_src <= 1'b1;
    repeat (20) @(posedge clk);
    check(sq.size(), 8);
    check(sr, 1'b0);
    $display("test buffer full done");
    stall <= 1'b0;
    hold <= 1'b0;
    repeat (60) @(posedge clk);
    en_src <= 1'b0;
    for (i = 0; i < 2000 && sq.size() > 0; i++) @(posedge clk);
    check(sq.size(), 0);
    check(sr, 1'b1);
    check(mode, 2);
    wb(0, 8'h08, 0);
    check(rd, 32'h80);
    $display("test stream done");
    hold <= 1'b1;
    mode = 0;
    repeat (10) @(posedge clk);
    check({lv, lk, ld}, {22'h0, 10'h3bc});
    wb(0, 8'h08, 0);
    check(rd, 32'h20);
    $display("test resync done");
    results();
  end
endmodule // jls_link_tb
